// *** common/hmbp_if.sv ***
// Pin bundle joining the host end and the device end of the micro bus port
`timescale 1ns/1ps
interface hmbp_if;
  // Select and shared control pins
  logic                          cs_n;
  logic                          strobe_line;
  logic                          dir_line;
  logic                          resp_line;
  logic                          addr_hold_strobe;
  logic [hmbp_pkg::ADDR_W-1:0]   addr;
  // Straps
  logic                          parallel_select;
  logic                          protocol_family_select;
  logic                          bus_multiplex_select;
  // Two-way data bus, one driver pair for each end
  logic [hmbp_pkg::DATA_W-1:0]   d_host_o;
  logic                          d_host_oe;
  logic [hmbp_pkg::DATA_W-1:0]   d_dev_o;
  logic                          d_dev_oe;
  logic [hmbp_pkg::DATA_W-1:0]   data;

  // Wire level; a floating bus reads as zero
  assign data = d_dev_oe ? d_dev_o : (d_host_oe ? d_host_o : '0);

  modport dev
  (
    input  cs_n, strobe_line, dir_line, addr_hold_strobe, addr, data,
    input  parallel_select, protocol_family_select, bus_multiplex_select,
    output resp_line, d_dev_o, d_dev_oe
  );

  modport host
  (
    output cs_n, strobe_line, dir_line, addr_hold_strobe, addr, d_host_o, d_host_oe,
    output parallel_select, protocol_family_select, bus_multiplex_select,
    input  resp_line, data
  );
endinterface : hmbp_if

// *** common/hmbp_pkg.sv ***
// Shared constants, strap codes and state encodings for the host micro bus port
//////////////////////////////////////////////////////////////////////////////
// Function
// - Shared strobe pin: shift clock, data strobe, read strobe
// - Serial input bits taken on shift clock rise
// - Serial output changes only on shift clock fall
// - Second pin: serial in, direction, write strobe
// - Third pin: serial out, acknowledge, ready
// - Host holds direction low write, high read
// - Direction style write captures data under strobe
// - Direction style read drives data under strobe
// - Acknowledge low when read valid or write taken
// - Host starts separate-strobe read with read strobe low
// - Device drives data during low read strobe
// - Host starts write with write strobe, presents data
// - Device captures data during low write strobe
// - Ready low for waits; host waits for high
// - Non-multiplexed: data pins data only, separate address
// - Multiplexed: data pins carry low address, then data
// - Host gives fresh select fall per access, holds
// - Address latched on address strobe fall when multiplexed
// - Select low serial, high parallel
// - Family and multiplex straps choose the bus style
//////////////////////////////////////////////////////////////////////////////
package hmbp_pkg;

  // Bus widths
  localparam int ADDR_W    = 11;
  localparam int DATA_W    = 8;
  localparam int ADDR_HI_W = 3;

  // Strap codes, read from the pins
  localparam logic SEL_SERIAL   = 1'b0;
  localparam logic FAMILY_DIR   = 1'b0;
  localparam logic MUX_ON       = 1'b1;

  // Serial frame: direction bit, address, one turnaround bit, data
  localparam int            SER_HDR_BITS   = 1 + ADDR_W;
  localparam int            SER_TURN_BIT   = SER_HDR_BITS + 1;
  localparam int            SER_FRAME_BITS = SER_TURN_BIT + DATA_W;
  localparam int            SER_CNT_W      = 5;
  localparam logic          SER_READ       = 1'b1;

  // Timing at the 40 MHz core clock
  localparam int CORE_CLK_NS    = 25;
  localparam int SCLK_PERIOD_NS = 200;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CORE_CLK_NS);
  localparam int HOST_HOLD_CYC  = 4;
  localparam int TMR_W          = 4;

  // Device end states
  typedef enum logic [3:0] {
    HMBP_D_IDLE  = 4'b0001,
    HMBP_D_SER   = 4'b0010,
    HMBP_D_PREQ  = 4'b0100,
    HMBP_D_PDONE = 4'b1000
  } hmbp_dstate_t;

  // Host end states
  typedef enum logic [5:0] {
    HMBP_H_IDLE  = 6'b000001,
    HMBP_H_SER   = 6'b000010,
    HMBP_H_ALE   = 6'b000100,
    HMBP_H_SETUP = 6'b001000,
    HMBP_H_STB   = 6'b010000,
    HMBP_H_END   = 6'b100000
  } hmbp_hstate_t;

endpackage : hmbp_pkg

// *** design/hmbp_device.sv ***
// Device end of the micro bus port: serial and both parallel styles to a core access port
`timescale 1ns/1ps
module hmbp_device
(
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  // Pins toward the host
  hmbp_if.dev                                link,
  // Access port toward the core
  output logic                               acc_req,
  output logic                               acc_write,
  output logic [hmbp_pkg::ADDR_W-1:0]        acc_addr,
  output logic [hmbp_pkg::DATA_W-1:0]        acc_wdata,
  input  wire logic                          acc_done,
  input  wire logic [hmbp_pkg::DATA_W-1:0]   acc_rdata
);
  import hmbp_pkg::*;

  localparam int SYNC_W = 7 + ADDR_W + DATA_W;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SYNC_W-1:0]       sync1_q;
  logic [SYNC_W-1:0]       sync2_q;
  wire  [SYNC_W-1:0]       pins_raw;
  wire                     cs_n_s;
  wire                     stb_s;
  wire                     dir_s;
  wire                     ahs_s;
  wire                     par_s;
  wire                     fam_s;
  wire                     mux_s;
  wire  [ADDR_W-1:0]       addr_s;
  wire  [DATA_W-1:0]       data_s;

  assign pins_raw = {link.cs_n, link.strobe_line, link.dir_line, link.addr_hold_strobe,
                     link.parallel_select, link.protocol_family_select, link.bus_multiplex_select,
                     link.addr, link.data};

  // Every pin, the shift clock among them, crosses two flops before use
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
    end
    else
    begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  assign {cs_n_s, stb_s, dir_s, ahs_s, par_s, fam_s, mux_s, addr_s, data_s} = sync2_q;

  //////////////////////////////////////////////////////////////////////////////
  // Mode decode from the straps
  wire ser_mode;
  wire par_mode;
  wire dir_style;
  wire sep_style;
  wire mux_mode;

  assign ser_mode  = (par_s == SEL_SERIAL);
  assign par_mode  = !ser_mode;
  assign dir_style = par_mode && (fam_s == FAMILY_DIR);
  assign sep_style = par_mode && !dir_style;
  assign mux_mode  = par_mode && (mux_s == MUX_ON);

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised levels
  logic cs_prev_q;
  logic stb_prev_q;
  logic ahs_prev_q;
  wire  cs_fall;
  wire  stb_rise;
  wire  stb_fall;
  wire  ahs_fall;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cs_prev_q  <= 1'b1;
      stb_prev_q <= 1'b1;
      ahs_prev_q <= 1'b1;
    end
    else
    begin
      cs_prev_q  <= cs_n_s;
      stb_prev_q <= stb_s;
      ahs_prev_q <= ahs_s;
    end
  end

  assign cs_fall  = cs_prev_q && !cs_n_s;
  assign stb_rise = !stb_prev_q && stb_s;
  assign stb_fall = stb_prev_q && !stb_s;
  assign ahs_fall = ahs_prev_q && !ahs_s;

  //////////////////////////////////////////////////////////////////////////////
  // Access decode for the parallel styles
  hmbp_dstate_t          state_q;
  logic                  armed_q;
  logic [ADDR_W-1:0]     mux_addr_q;
  wire                   par_active;
  wire                   par_start;
  wire                   par_release;
  wire                   par_write;
  wire [ADDR_W-1:0]      par_addr;

  // Data strobe alone in the direction style; either strobe in the other
  assign par_active  = dir_style ? !stb_s : (!stb_s || !dir_s);
  assign par_start   = (state_q == HMBP_D_IDLE) && par_mode && !cs_n_s && armed_q && par_active;
  assign par_release = cs_n_s || (dir_style ? stb_s : (stb_s && dir_s));
  // Direction low means write; write strobe low also means write
  assign par_write   = !dir_s;
  assign par_addr    = mux_mode ? mux_addr_q : addr_s;

  // Multiplexed address: upper pins plus the data byte on the strobe fall
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      mux_addr_q <= '0;
    else if (mux_mode && ahs_fall)
      mux_addr_q <= {addr_s[ADDR_W-1 -: ADDR_HI_W], data_s};
  end

  // A select must go high again before the next access is taken
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      armed_q <= 1'b0;
    else if (cs_n_s)
      armed_q <= 1'b1;
    else if (par_start || (state_q == HMBP_D_IDLE && ser_mode && cs_fall))
      armed_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial shift path
  logic [SER_FRAME_BITS-1:0] ser_sh_q;
  logic [SER_CNT_W-1:0]      ser_cnt_q;
  logic                      ser_rw_q;
  logic [DATA_W-1:0]         out_sh_q;
  logic                      serial_out_q;
  wire  [SER_FRAME_BITS-1:0] ser_sh_d;
  wire                       ser_bit;
  wire                       ser_hdr_done;
  wire                       ser_frame_done;
  wire                       ser_shift_out;

  assign ser_sh_d       = {ser_sh_q[SER_FRAME_BITS-2:0], dir_s};
  assign ser_bit        = (state_q == HMBP_D_SER) && stb_rise;
  assign ser_hdr_done   = ser_bit && (ser_cnt_q == SER_CNT_W'(SER_HDR_BITS - 1));
  assign ser_frame_done = ser_bit && (ser_cnt_q == SER_CNT_W'(SER_FRAME_BITS - 1));
  // Output moves only from the turnaround bit on, and only on a fall
  assign ser_shift_out  = (state_q == HMBP_D_SER) && stb_fall && (ser_rw_q == SER_READ)
                          && (ser_cnt_q >= SER_CNT_W'(SER_TURN_BIT));

  // Input shift register and bit counter
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ser_sh_q  <= '0;
      ser_cnt_q <= '0;
      ser_rw_q  <= 1'b0;
    end
    else if (state_q != HMBP_D_SER)
      ser_cnt_q <= '0;
    else if (ser_bit)
    begin
      ser_sh_q  <= ser_sh_d;
      ser_cnt_q <= ser_cnt_q + 1'b1;
      if (ser_hdr_done)
        ser_rw_q <= ser_sh_d[SER_HDR_BITS-1];
    end
  end

  // Read data is loaded on completion; a late completion misses the frame
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out_sh_q     <= '0;
      serial_out_q <= 1'b0;
    end
    else if (acc_done)
      out_sh_q <= acc_rdata;
    else if (ser_shift_out)
    begin
      serial_out_q <= out_sh_q[DATA_W-1];
      out_sh_q     <= {out_sh_q[DATA_W-2:0], 1'b0};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Access state machine
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= HMBP_D_IDLE;
    else
    begin
      case (state_q)
        HMBP_D_IDLE:
          if (ser_mode && cs_fall && armed_q)
            state_q <= HMBP_D_SER;
          else if (par_start)
            state_q <= HMBP_D_PREQ;
        HMBP_D_SER:
          if (cs_n_s)
            state_q <= HMBP_D_IDLE;
        HMBP_D_PREQ:
          if (acc_done)
            state_q <= HMBP_D_PDONE;
        HMBP_D_PDONE:
          if (par_release)
            state_q <= HMBP_D_IDLE;
        default:
          state_q <= HMBP_D_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Core access request, one pulse per access
  logic                  acc_req_q;
  logic                  acc_write_q;
  logic [ADDR_W-1:0]     acc_addr_q;
  logic [DATA_W-1:0]     acc_wdata_q;
  logic [DATA_W-1:0]     rdata_q;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_req_q   <= 1'b0;
      acc_write_q <= 1'b0;
      acc_addr_q  <= '0;
      acc_wdata_q <= '0;
    end
    else if (par_start)
    begin
      acc_req_q   <= 1'b1;
      acc_write_q <= par_write;
      acc_addr_q  <= par_addr;
      acc_wdata_q <= data_s;
    end
    else if (ser_hdr_done)
    begin
      // Reads go out as soon as the address is known
      acc_req_q   <= (ser_sh_d[SER_HDR_BITS-1] == SER_READ);
      acc_write_q <= (ser_sh_d[SER_HDR_BITS-1] != SER_READ);
      acc_addr_q  <= ser_sh_d[ADDR_W-1:0];
    end
    else if (ser_frame_done && ser_rw_q != SER_READ)
    begin
      acc_req_q   <= 1'b1;
      acc_wdata_q <= ser_sh_d[DATA_W-1:0];
    end
    else
      acc_req_q <= 1'b0;
  end

  // Read data held for the bus drivers
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_q <= '0;
    else if (acc_done)
      rdata_q <= acc_rdata;
  end

  assign acc_req   = acc_req_q;
  assign acc_write = acc_write_q;
  assign acc_addr  = acc_addr_q;
  assign acc_wdata = acc_wdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Shared response pin and data bus drivers
  wire done_phase;

  assign done_phase    = (state_q == HMBP_D_PDONE);
  // Serial output, active-low acknowledge, or ready high to finish
  assign link.resp_line = ser_mode ? serial_out_q :
                          (dir_style ? !done_phase : done_phase);
  // Drive only valid read data, only while the read strobe is low
  assign link.d_dev_o   = rdata_q;
  assign link.d_dev_oe  = done_phase && !acc_write_q && !stb_s && !cs_n_s;

endmodule : hmbp_device

// *** design/hmbp_host.sv ***
// Host end of the micro bus port: runs one access per command in the strapped style
`timescale 1ns/1ps
module hmbp_host
(
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  // Pins toward the device
  hmbp_if.host                               link,
  // Strap choices
  input  wire logic                          cfg_parallel,
  input  wire logic                          cfg_family,
  input  wire logic                          cfg_mux,
  // Command port
  input  wire logic                          cmd_valid,
  input  wire logic                          cmd_write,
  input  wire logic [hmbp_pkg::ADDR_W-1:0]   cmd_addr,
  input  wire logic [hmbp_pkg::DATA_W-1:0]   cmd_wdata,
  output logic                               cmd_ready,
  output logic                               cmd_done,
  output logic [hmbp_pkg::DATA_W-1:0]        cmd_rdata
);
  import hmbp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Response and data synchronisers
  logic [DATA_W:0] rs1_q;
  logic [DATA_W:0] rs2_q;
  wire             resp_s;
  wire [DATA_W-1:0] data_s;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rs1_q <= '0;
      rs2_q <= '0;
    end
    else
    begin
      rs1_q <= {link.resp_line, link.data};
      rs2_q <= rs1_q;
    end
  end

  assign {resp_s, data_s} = rs2_q;

  //////////////////////////////////////////////////////////////////////////////
  // Mode and response polarity
  wire ser_mode;
  wire fam_dir;
  wire mux_mode;
  wire resp_ok;

  assign ser_mode = (cfg_parallel == SEL_SERIAL);
  assign fam_dir  = (cfg_family == FAMILY_DIR);
  assign mux_mode = !ser_mode && (cfg_mux == MUX_ON);
  assign resp_ok  = fam_dir ? !resp_s : resp_s;

  //////////////////////////////////////////////////////////////////////////////
  // Access sequencer
  hmbp_hstate_t              state_q;
  logic [TMR_W-1:0]          tmr_q;
  logic [SER_CNT_W-1:0]      bit_q;
  logic [SER_FRAME_BITS-1:0] sh_q;
  logic [DATA_W-1:0]         rd_sh_q;
  logic                      we_q;
  logic [DATA_W-1:0]         wdata_q;
  logic                      cs_n_q;
  logic                      stb_q;
  logic                      dir_q;
  logic                      ahs_q;
  logic [ADDR_W-1:0]         addr_q;
  logic [DATA_W-1:0]         dout_q;
  logic                      doe_q;
  logic                      done_q;
  logic [DATA_W-1:0]         rdata_q;
  wire                       tmr_zero;

  assign tmr_zero = (tmr_q == '0);

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= HMBP_H_IDLE;
      tmr_q   <= '0;
      bit_q   <= '0;
      sh_q    <= '0;
      rd_sh_q <= '0;
      we_q    <= 1'b0;
      wdata_q <= '0;
      cs_n_q  <= 1'b1;
      stb_q   <= 1'b1;
      dir_q   <= 1'b1;
      ahs_q   <= 1'b0;
      addr_q  <= '0;
      dout_q  <= '0;
      doe_q   <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      done_q <= 1'b0;
      if (!tmr_zero)
        tmr_q <= tmr_q - 1'b1;
      case (state_q)
        HMBP_H_IDLE:
        begin
          // Idle levels follow the strapped style
          stb_q <= !ser_mode;
          dir_q <= !ser_mode;
          ahs_q <= !ser_mode && !mux_mode;
          if (cmd_valid)
          begin
            cs_n_q  <= 1'b0;
            we_q    <= cmd_write;
            wdata_q <= cmd_wdata;
            tmr_q   <= TMR_W'(HOST_HOLD_CYC - 1);
            if (ser_mode)
            begin
              sh_q    <= {cmd_write ? ~SER_READ : SER_READ, cmd_addr, 1'b0, cmd_wdata};
              bit_q   <= '0;
              // First bit set up a half period ahead of the first rise
              dir_q   <= cmd_write ? ~SER_READ : SER_READ;
              tmr_q   <= TMR_W'(SCLK_HALF_CYC - 1);
              state_q <= HMBP_H_SER;
            end
            else if (mux_mode)
            begin
              ahs_q   <= 1'b1;
              addr_q  <= {cmd_addr[ADDR_W-1 -: ADDR_HI_W], {(ADDR_W-ADDR_HI_W){1'b0}}};
              dout_q  <= cmd_addr[DATA_W-1:0];
              doe_q   <= 1'b1;
              state_q <= HMBP_H_ALE;
            end
            else
            begin
              addr_q  <= cmd_addr;
              state_q <= HMBP_H_ALE;
            end
          end
        end
        HMBP_H_SER:
          if (tmr_zero)
          begin
            tmr_q <= TMR_W'(SCLK_HALF_CYC - 1);
            if (!stb_q)
            begin
              stb_q <= 1'b1;
            end
            else
            begin
              // Sample late in the high phase, after the fall-timed change settled
              rd_sh_q <= {rd_sh_q[DATA_W-2:0], resp_s};
              stb_q   <= 1'b0;
              // Next bit moves on the fall, so it never races the rise that takes it
              dir_q   <= sh_q[SER_FRAME_BITS-2];
              sh_q    <= {sh_q[SER_FRAME_BITS-2:0], 1'b0};
              bit_q   <= bit_q + 1'b1;
              if (bit_q == SER_CNT_W'(SER_FRAME_BITS - 1))
                state_q <= HMBP_H_END;
            end
          end
        HMBP_H_ALE:
          if (tmr_zero)
          begin
            tmr_q <= TMR_W'(HOST_HOLD_CYC - 1);
            if (ahs_q && mux_mode)
              ahs_q <= 1'b0;
            else
            begin
              dout_q  <= wdata_q;
              doe_q   <= we_q;
              if (fam_dir)
                dir_q <= !we_q;
              state_q <= HMBP_H_SETUP;
            end
          end
        HMBP_H_SETUP:
          if (tmr_zero)
          begin
            if (fam_dir || !we_q)
              stb_q <= 1'b0;
            else
              dir_q <= 1'b0;
            state_q <= HMBP_H_STB;
          end
        HMBP_H_STB:
          if (resp_ok)
          begin
            rdata_q <= data_s;
            stb_q   <= 1'b1;
            dir_q   <= fam_dir ? dir_q : 1'b1;
            doe_q   <= 1'b0;
            tmr_q   <= TMR_W'(HOST_HOLD_CYC - 1);
            state_q <= HMBP_H_END;
          end
        HMBP_H_END:
          if (tmr_zero)
          begin
            if (!cs_n_q)
            begin
              cs_n_q <= 1'b1;
              tmr_q  <= TMR_W'(HOST_HOLD_CYC - 1);
              if (ser_mode)
                rdata_q <= rd_sh_q;
            end
            else
            begin
              done_q  <= 1'b1;
              state_q <= HMBP_H_IDLE;
            end
          end
        default:
          state_q <= HMBP_H_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin and command outputs
  assign link.cs_n                   = cs_n_q;
  assign link.strobe_line            = stb_q;
  assign link.dir_line               = dir_q;
  assign link.addr_hold_strobe       = ahs_q;
  assign link.addr                   = addr_q;
  assign link.d_host_o               = dout_q;
  assign link.d_host_oe              = doe_q;
  assign link.parallel_select        = cfg_parallel;
  assign link.protocol_family_select = cfg_family;
  assign link.bus_multiplex_select   = cfg_mux;
  assign cmd_ready                   = (state_q == HMBP_H_IDLE);
  assign cmd_done                    = done_q;
  assign cmd_rdata                   = rdata_q;

endmodule : hmbp_host

// *** verif/hmbp_monitor.sv ***
// Checker on the pins between the host end and the device end
`timescale 1ns/1ps
module hmbp_monitor
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Pins
  input wire logic cs_n,
  input wire logic strobe_line,
  input wire logic dir_line,
  input wire logic resp_line,
  input wire logic addr_hold_strobe,
  input wire logic parallel_select,
  input wire logic protocol_family_select,
  input wire logic bus_multiplex_select,
  input wire logic d_host_oe,
  input wire logic d_dev_oe
);
  import hmbp_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Style decodes; straps only change while the bus is idle
  wire dir_sty = parallel_select && protocol_family_select == FAMILY_DIR;
  wire sep_sty = parallel_select && protocol_family_select != FAMILY_DIR;
  // Mode changes move idle pin levels with the select high, so real accesses are told apart by cs_n
  wire mux_sty = parallel_select && bus_multiplex_select == MUX_ON;
  wire ser_on  = !parallel_select && !cs_n;
  sequence ack_start; dir_sty && $fell(resp_line); endsequence
  sequence ack_held; !resp_line [*3]; endsequence
  //////////////////////////////////////////
  chk_ack_in_access: assert property (ack_start |-> !cs_n && !strobe_line)
    else $error("ack outside access");
  chk_ack_holds: assert property (ack_start |=> ack_held)
    else $error("ack too short");
  chk_ack_with_data: assert property ((ack_start and dir_line) |-> d_dev_oe)
    else $error("ack before read data");
  chk_ready_in_access: assert property (sep_sty && $rose(resp_line) |-> !cs_n && (!strobe_line || !dir_line))
    else $error("ready outside access");
  chk_read_drive: assert property ($rose(d_dev_oe) |-> !cs_n && !strobe_line && !d_host_oe)
    else $error("data driven off read");
  chk_serial_quiet: assert property (!parallel_select |-> !d_dev_oe)
    else $error("data driven in serial");
  chk_serial_out_fall: assert property (ser_on && !$past(cs_n, 4) && $changed(resp_line) |-> !strobe_line)
    else $error("serial out moved in high phase");
  chk_mux_addr_drive: assert property (mux_sty && !cs_n && $fell(addr_hold_strobe) |-> d_host_oe)
    else $error("no address on data pins");
  chk_dir_steady: assert property (dir_sty && !strobe_line && $past(strobe_line) == 1'b0 |-> $stable(dir_line))
    else $error("direction moved under strobe");
endmodule : hmbp_monitor

// *** verif/tb_host_micro_bus_port.sv ***
// Bench: host end and device end joined, core responder, access sequences in every style
`timescale 1ns/1ps
module tb_host_micro_bus_port;
  import hmbp_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [2:0]        cfg = 3'h0;
  logic              cmd_valid = 1'b0;
  logic              cmd_write = 1'b0;
  logic              acc_done = 1'b0;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [DATA_W-1:0] cmd_wdata = '0;
  logic [DATA_W-1:0] acc_rdata = '0;
  logic [DATA_W-1:0] cmd_rdata;
  logic              cmd_ready, cmd_done, acc_req, acc_write;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic [19:0]       acc_seen = '0;
  logic [1:0]        dly = '0;
  int                err_total = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  hmbp_if link_if ();
  hmbp_host hmbp_host_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link_if.host), .cfg_parallel(cfg[2]),
    .cfg_family(cfg[1]), .cfg_mux(cfg[0]), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_rdata(cmd_rdata));
  hmbp_device hmbp_device_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link_if.dev), .acc_req(acc_req),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_rdata(acc_rdata));
  hmbp_monitor hmbp_monitor_inst (.core_clk(core_clk), .rst_b(rst_b), .cs_n(link_if.cs_n),
    .strobe_line(link_if.strobe_line), .dir_line(link_if.dir_line), .resp_line(link_if.resp_line),
    .addr_hold_strobe(link_if.addr_hold_strobe), .parallel_select(link_if.parallel_select),
    .protocol_family_select(link_if.protocol_family_select), .bus_multiplex_select(link_if.bus_multiplex_select),
    .d_host_oe(link_if.d_host_oe), .d_dev_oe(link_if.d_dev_oe));
  //////////////////////////////////////////
  // Clock, and a ceiling far above the ten accesses of the run
  initial
  forever #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      results();
    end
  end
  // Core responder: answers two cycles after a request, well inside the serial read budget
  always @(negedge core_clk)
  begin
    acc_done <= (dly == 2'h1);
    dly <= acc_req ? 2'h2 : (dly != 2'h0 ? dly - 2'h1 : 2'h0);
    acc_rdata <= acc_addr[7:0] ^ 8'h5a;
    if (acc_req === 1'b1)
      acc_seen <= {acc_write, acc_addr, acc_wdata};
  end
  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // One command, entered at a falling edge; the ceiling bounds the wait for done
  task automatic access(input logic w, input logic [10:0] a, input logic [7:0] d);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (cmd_done !== 1'b1)
      @(negedge core_clk);
    @(negedge core_clk);
  endtask : access
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  // Serial, then direction and split-strobe styles, each plain and multiplexed
  initial
  begin
    repeat (8) @(negedge core_clk);
    rst_b = 1'b1;
    for (int m = 0; m < 5; m++)
    begin
      cfg = (m == 0) ? 3'h0 : {1'b1, 2'(m % 4)};
      repeat (8) @(negedge core_clk);
      access(1'b1, 11'h6a5 - 11'(m), 8'hc3 ^ 8'(m));
      check("write", acc_seen, {1'b1, 11'h6a5 - 11'(m), 8'hc3 ^ 8'(m)});
      access(1'b0, 11'h13c + 11'(m), 8'h00);
      check("read addr", {8'h00, acc_seen[19:8]}, {9'h000, 11'h13c + 11'(m)});
      check("read data", {12'h000, cmd_rdata}, {12'h000, (8'h3c + 8'(m)) ^ 8'h5a});
      check("idle", {18'h00000, cmd_ready, link_if.cs_n}, 20'h00003);
    end
    results();
  end
endmodule : tb_host_micro_bus_port
